// >>> gateway_diag_and_input_map.sv
/*
  Checks master output commands, collects diagnostic conditions and
  builds the input image of the gateway. Assumes all inputs come from
  logic on clk: the output image strobe, the module table lookup, the
  response path of the HART channels and the queue logic.
*/
`timescale 1ns/10ps
module gateway_diag_and_input_map
  import gw_diag_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // configuration from parameter download
  input wire logic fmt_raw,
  input wire logic cfg_valid,
  input wire logic cfg_slot_present,
  input wire logic cfg_slot_first,
  input wire logic [7:0] cfg_burst_count,
  input wire logic cfg_cmd_mod_present,
  input wire logic cfg_len_mod_present,
  // master output image, one strobe per data exchange
  input wire logic out_valid,
  input wire logic [7:0] out_trig,
  input wire logic [7:0] out_ctrl,
  input wire logic [7:0] out_sel,
  input wire logic [7:0] out_chan,
  input wire logic [7:0] out_pre,
  input wire logic [7:0] out_len,
  // module table lookup for out_sel
  input wire logic [1:0] sel_mode,
  input wire logic [1:0] sel_chan,
  // queued command towards the slave
  output logic cmd_push,
  output logic [1:0] cmd_chan,
  output logic [7:0] cmd_pre,
  output logic [7:0] cmd_len,
  output logic [7:0] cmd_module,
  // channel and queue events
  input wire logic [3:0] burst_seen,
  input wire logic cmd_sent,
  input wire logic txq_overflow,
  input wire logic rxq_overflow,
  input wire logic nv_rd_fail,
  input wire logic nv_wr_fail,
  input wire logic [15:0] txq_count,
  // response path
  input wire logic rx_start,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic resp_valid,
  input wire logic [1:0] resp_chan,
  input wire logic [7:0] resp_len,
  input wire logic [6:0] resp_module,
  input wire logic [15:0] resp_cmd_id,
  input wire logic [2:0] resp_fault,
  input wire logic [3:0] resp_slave_status,
  // input image read port
  input wire logic [7:0] in_addr,
  output logic [7:0] in_data,
  // diagnostics read port
  input wire logic [3:0] diag_idx,
  output logic [CODE_W-1:0] diag_code,
  output logic [3:0] diag_count
);
  typedef struct packed {
    logic [7:0] trig;
    logic seen;
    logic [31:0] pend;
    logic push;
    logic [1:0] chan;
    logic [7:0] pre;
    logic [7:0] len;
    logic [7:0] module_sel;
    logic [1:0] rsp_chan;
    logic [7:0] rsp_len;
    logic [15:0] err_id;
    logic [7:0] wr_idx;
    logic [7:0] rd;
    rx_state_t rx;
  } main_st_t;

  main_st_t st_r;
  main_st_t st_nxt;
  logic [7:0] rx_mem [DATA_BYTES];
  logic [CNT_W-1:0] sent_cnt;
  logic [CNT_W-1:0] recv_cnt;
  logic [CNT_W-1:0] fail_cnt;
  logic [31:0] ev;
  logic trig_new;
  logic trig_bad;
  logic pre_bad;
  logic chan_bad;
  logic mode_bad;
  logic [1:0] tgt_chan;
  logic resp_fail;
  logic clr;
  logic push_diag;
  logic [CODE_W-1:0] push_code;
  logic [16:0] fill_sum;
  logic [7:0] fill_lvl;
  logic rx_wr;

  assign trig_new = out_valid && (!st_r.seen || (out_trig != st_r.trig));
  // trigger must step by exactly one
  assign trig_bad = out_valid && st_r.seen && (out_trig != st_r.trig)
                    && (out_trig != st_r.trig + 8'h01);
  assign chan_bad = fmt_raw && (out_chan > CHAN_MAX);
  assign pre_bad = fmt_raw && ((out_pre < PRE_MIN) || (out_pre > PRE_MAX));
  assign mode_bad = !fmt_raw && (out_sel != 8'h00) && (sel_mode != MODE_MANUAL);
  assign tgt_chan = fmt_raw ? out_chan[1:0] : sel_chan;
  assign resp_fail = resp_valid && (resp_fault != 3'h0);
  assign clr = out_valid && out_ctrl[CTRL_CLR_BIT];
  assign fill_sum = {1'b0, txq_count} + 17'h00001;
  assign rx_wr = rx_byte_valid && (st_r.rx == RX_DATA)
                 && (st_r.wr_idx < 8'(DATA_BYTES));

  // one-cycle events, one bit per diagnostic code
  always_comb begin
    ev = '0;
    if (resp_fail && (resp_module >= CMD_MOD_FIRST) && (resp_module <= CMD_MOD_LAST)) begin
      ev[DG_RESP_BASE + 5'(resp_fault) - 5'h01] = 1'b1;
    end
    // slave conditions relayed in raw format
    if (resp_valid && fmt_raw && (resp_slave_status != 4'h0)
        && (resp_slave_status <= 4'h8)) begin
      ev[DG_SLAVE_BASE + 5'(resp_slave_status) - 5'h01] = 1'b1;
    end
    ev[DG_NO_SLOT] = cfg_valid && !cfg_slot_present;
    ev[DG_SLOT_POS] = cfg_valid && cfg_slot_present && !cfg_slot_first;
    ev[DG_BURST_MANY] = cfg_valid && (cfg_burst_count > 8'h01);
    ev[DG_WRONG_MOD] = cfg_valid && ((fmt_raw && cfg_cmd_mod_present)
                       || (!fmt_raw && cfg_len_mod_present));
    ev[DG_TXQ_OVF] = txq_overflow;
    ev[DG_RXQ_OVF] = rxq_overflow;
    ev[DG_NV_RD] = nv_rd_fail;
    ev[DG_NV_WR] = nv_wr_fail;
    ev[DG_LOST_OUT] = trig_bad;
    ev[DG_CHAN_RANGE] = trig_new && chan_bad;
    ev[DG_PRE_RANGE] = trig_new && pre_bad;
    ev[DG_NOT_MANUAL] = trig_new && mode_bad;
    ev[DG_BURST_BUS] = trig_new && !chan_bad && burst_seen[tgt_chan];
  end

  // lowest pending code goes to the store first
  always_comb begin
    push_diag = 1'b0;
    push_code = '0;
    for (int i = 31; i > 0; i--) begin
      if (st_r.pend[i]) begin
        push_diag = 1'b1;
        push_code = 5'(i);
      end
    end
  end

  // level is half the queue count rounded up, kept in 1..255
  always_comb begin
    if (fill_sum[16:1] > 16'(FILL_MAX)) begin
      fill_lvl = FILL_MAX;
    end else if (fill_sum[16:1] == 16'h0000) begin
      fill_lvl = FILL_MIN;
    end else begin
      fill_lvl = fill_sum[8:1];
    end
  end

  always_comb begin
    st_nxt = st_r;
    // offered code leaves pending whether stored or dropped when full
    if (push_diag) begin
      st_nxt.pend[push_code] = 1'b0;
    end
    // clear also drops conditions not yet stored; new events win
    if (clr) begin
      st_nxt.pend = '0;
    end
    st_nxt.pend = st_nxt.pend | ev;
    st_nxt.push = 1'b0;
    if (out_valid) begin
      st_nxt.trig = out_trig;
      st_nxt.seen = 1'b1;
    end
    if (trig_new && st_r.seen && !chan_bad && !mode_bad) begin
      st_nxt.push = 1'b1;
      st_nxt.chan = tgt_chan;
      st_nxt.pre = pre_bad ? PRE_SUBST : out_pre;
      st_nxt.len = out_len;
      st_nxt.module_sel = out_sel;
    end
    // response frame capture
    case (st_r.rx)
      RX_IDLE: begin
        if (rx_start) begin
          st_nxt.rx = RX_DATA;
          st_nxt.wr_idx = '0;
        end
      end
      RX_DATA: begin
        // data beyond byte 239 is dropped
        if (rx_wr) begin
          st_nxt.wr_idx = st_r.wr_idx + 8'h01;
        end
        if (resp_valid) begin
          st_nxt.rx = RX_IDLE;
        end
      end
      default: begin
        st_nxt.rx = RX_IDLE;
      end
    endcase
    // channel and length of the response
    if (resp_valid) begin
      st_nxt.rsp_chan = resp_chan;
      st_nxt.rsp_len = resp_len;
    end
    if (resp_fail) begin
      st_nxt.err_id = resp_cmd_id;
    end
    case (in_addr)
      OFF_PEND: st_nxt.rd = txq_count[15:8];
      OFF_PEND + 8'h01: st_nxt.rd = txq_count[7:0];
      OFF_SENT: st_nxt.rd = sent_cnt[15:8];
      OFF_SENT + 8'h01: st_nxt.rd = sent_cnt[7:0];
      OFF_RECV: st_nxt.rd = recv_cnt[15:8];
      OFF_RECV + 8'h01: st_nxt.rd = recv_cnt[7:0];
      OFF_FAIL: st_nxt.rd = fail_cnt[15:8];
      OFF_FAIL + 8'h01: st_nxt.rd = fail_cnt[7:0];
      OFF_ERRID: st_nxt.rd = st_r.err_id[15:8];
      OFF_ERRID + 8'h01: st_nxt.rd = st_r.err_id[7:0];
      OFF_CHAN: st_nxt.rd = {6'h00, st_r.rsp_chan};
      OFF_LEN: st_nxt.rd = st_r.rsp_len;
      OFF_FILL: st_nxt.rd = fill_lvl;
      default: begin
        // response data area, zero beyond the image
        if ((in_addr >= DATA_FIRST) && (in_addr <= DATA_LAST)) begin
          st_nxt.rd = rx_mem[in_addr - DATA_FIRST];
        end else begin
          st_nxt.rd = 8'h00;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '{rx: RX_IDLE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // memory kept outside the state struct so it maps to a RAM
  always_ff @(posedge clk) begin
    if (rx_wr) begin
      rx_mem[st_r.wr_idx] <= rx_byte;
    end
  end

  event_counter #(.W(CNT_W)) u_sent (
    .clk(clk),
    .srst(srst),
    .inc(cmd_sent),
    .q(sent_cnt)
  );

  event_counter #(.W(CNT_W)) u_recv (
    .clk(clk),
    .srst(srst),
    .inc(resp_valid),
    .q(recv_cnt)
  );

  event_counter #(.W(CNT_W)) u_fail (
    .clk(clk),
    .srst(srst),
    .inc(resp_fail),
    .q(fail_cnt)
  );

  diag_store #(.DEPTH(DIAG_MAX)) u_diag (
    .clk(clk),
    .srst(srst),
    .push(push_diag),
    .code(push_code),
    .clr(clr),
    .rd_idx(diag_idx),
    .rd_code(diag_code),
    .count(diag_count)
  );

  assign cmd_push = st_r.push;
  assign cmd_chan = st_r.chan;
  assign cmd_pre = st_r.pre;
  assign cmd_len = st_r.len;
  assign cmd_module = st_r.module_sel;
  assign in_data = st_r.rd;

  property p_lost;
    @(posedge clk) disable iff (srst)
      (out_valid && st_r.seen && out_trig != st_r.trig
       && out_trig != st_r.trig + 8'h01) |=> st_r.pend[DG_LOST_OUT];
  endproperty
  a_lost: assert property (p_lost) else $error("lost output data not flagged");

  property p_wrap;
    @(posedge clk) disable iff (srst)
      (out_valid && st_r.seen && st_r.trig == 8'hFF && out_trig == 8'h00)
      |=> !st_r.pend[DG_LOST_OUT] || $past(st_r.pend[DG_LOST_OUT]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap of trigger flagged");

  property p_chan;
    @(posedge clk) disable iff (srst)
      (trig_new && fmt_raw && out_chan > CHAN_MAX) |=> st_r.pend[DG_CHAN_RANGE] && !cmd_push;
  endproperty
  a_chan: assert property (p_chan) else $error("channel range not checked");

  property p_pre;
    @(posedge clk) disable iff (srst)
      (trig_new && st_r.seen && fmt_raw && !chan_bad && (out_pre < PRE_MIN || out_pre > PRE_MAX))
      |=> cmd_push && cmd_pre == PRE_SUBST && st_r.pend[DG_PRE_RANGE];
  endproperty
  a_pre: assert property (p_pre) else $error("preamble not substituted");

  property p_manual;
    @(posedge clk) disable iff (srst)
      (trig_new && !fmt_raw && out_sel != 8'h00 && sel_mode != MODE_MANUAL)
      |=> st_r.pend[DG_NOT_MANUAL] && !cmd_push;
  endproperty
  a_manual: assert property (p_manual) else $error("non-manual module sent");

  property p_burst;
    @(posedge clk) disable iff (srst)
      (cfg_valid && cfg_burst_count > 8'h01) |=> st_r.pend[DG_BURST_MANY];
  endproperty
  a_burst: assert property (p_burst) else $error("burst module count not checked");

  property p_fill;
    @(posedge clk) disable iff (srst) (in_addr == OFF_FILL) |=> in_data != 8'h00;
  endproperty
  a_fill: assert property (p_fill) else $error("fill level reads zero");

  property p_resp;
    @(posedge clk) disable iff (srst)
      resp_valid |=> st_r.rsp_len == $past(resp_len) && st_r.rsp_chan == $past(resp_chan);
  endproperty
  a_resp: assert property (p_resp) else $error("response channel or length not kept");
endmodule

// >>> gw_diag_pkg.sv
/*
  Constants, codes and types shared by the gateway diagnostic and input
  image logic. Assumes one 100 MHz clock and a synchronous reset.
*/
// Behaviour
// - at most fifteen diagnostics pending; further ones are dropped
// - response faults of command modules 2..111 become diagnostics
// - raw format relays eight slave-reported conditions as diagnostics
// - control slot missing, or not first, gives two distinct diagnostics
// - queue overflows and store read/write failures each give a diagnostic
// - trigger byte must step by one, 255 wraps to 0, else lost-data
// - output channel above 3 gives channel-out-of-range diagnostic
// - preamble below 5 or above 20 becomes 20 plus a diagnostic; compact format passes out_pre unchecked
// - module-based select of a non-manual module gives a diagnostic
// - command on a channel with seen burst frames gives a diagnostic
// - more than one burst module configured gives a diagnostic
// - wrong module kind for the selected frame format gives a diagnostic
// - input image is 240 bytes; response data fills bytes 13..239
// - bytes 0-1 pending, 2-3 sent, 4-5 received command counters
// - bytes 6-7 failed count, bytes 8-9 identifier of failed command
// - byte 10 response channel, byte 11 response length
// - byte 12 queue fill level 1..255, level L holds 2L or 2L-1
// - control byte 1 bit 0 written as one clears all diagnostics; a code offered to the store in that cycle stays
// - change of trigger byte queues the command towards the slave, except the first after reset or on a bad channel or non-manual module
package gw_diag_pkg;
  localparam int DIAG_MAX = 15;
  localparam int CODE_W = 5;
  localparam logic [6:0] CMD_MOD_FIRST = 7'h02;
  localparam logic [6:0] CMD_MOD_LAST = 7'h6F;
  localparam logic [7:0] CHAN_MAX = 8'h03;
  localparam logic [7:0] PRE_MIN = 8'h05;
  localparam logic [7:0] PRE_MAX = 8'h14;
  localparam logic [7:0] PRE_SUBST = 8'h14;
  localparam int CTRL_CLR_BIT = 0;
  localparam int IMG_BYTES = 240;
  localparam logic [7:0] DATA_FIRST = 8'h0D;
  localparam logic [7:0] DATA_LAST = 8'hEF;
  localparam int DATA_BYTES = 227;
  // input image byte offsets, high byte of each pair first
  localparam logic [7:0] OFF_PEND = 8'h00;
  localparam logic [7:0] OFF_SENT = 8'h02;
  localparam logic [7:0] OFF_RECV = 8'h04;
  localparam logic [7:0] OFF_FAIL = 8'h06;
  localparam logic [7:0] OFF_ERRID = 8'h08;
  localparam logic [7:0] OFF_CHAN = 8'h0A;
  localparam logic [7:0] OFF_LEN = 8'h0B;
  localparam logic [7:0] OFF_FILL = 8'h0C;
  localparam logic [7:0] FILL_MAX = 8'hFF;
  localparam logic [7:0] FILL_MIN = 8'h01;
  // diagnostic codes; code 0 is never used
  localparam logic [4:0] DG_RESP_BASE = 5'h01;
  localparam logic [4:0] DG_SLAVE_BASE = 5'h08;
  localparam logic [4:0] DG_NO_SLOT = 5'h10;
  localparam logic [4:0] DG_SLOT_POS = 5'h11;
  localparam logic [4:0] DG_TXQ_OVF = 5'h12;
  localparam logic [4:0] DG_LOST_OUT = 5'h13;
  localparam logic [4:0] DG_CHAN_RANGE = 5'h14;
  localparam logic [4:0] DG_PRE_RANGE = 5'h15;
  localparam logic [4:0] DG_NOT_MANUAL = 5'h16;
  localparam logic [4:0] DG_BURST_BUS = 5'h17;
  localparam logic [4:0] DG_BURST_MANY = 5'h18;
  localparam logic [4:0] DG_WRONG_MOD = 5'h19;
  localparam logic [4:0] DG_RXQ_OVF = 5'h1A;
  localparam logic [4:0] DG_NV_RD = 5'h1B;
  localparam logic [4:0] DG_NV_WR = 5'h1C;

  typedef enum logic [1:0] {
    MODE_INITIAL = 2'h0,
    MODE_POLLING = 2'h1,
    MODE_MANUAL = 2'h2,
    MODE_BURST = 2'h3
  } out_mode_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_DATA = 2'b10
  } rx_state_t;
endpackage

// >>> event_counter.sv
/*
  Saturation-free wrapping event counter, one step per pulse.
  Assumes inc is a single-cycle pulse on clk.
*/
`timescale 1ns/10ps
module event_counter #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // event
  input wire logic inc,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } cnt_st_t;

  cnt_st_t st_r;
  cnt_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (inc) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.cnt;
endmodule

// >>> diag_store.sv
/*
  Holds the pending diagnostic codes for the master to read out.
  Assumes at most one new code per cycle; duplicates are kept once.
*/
`timescale 1ns/10ps
module diag_store
  import gw_diag_pkg::*;
#(
  parameter int DEPTH = DIAG_MAX
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // new code and clear
  input wire logic push,
  input wire logic [CODE_W-1:0] code,
  input wire logic clr,
  // read side
  input wire logic [3:0] rd_idx,
  output logic [CODE_W-1:0] rd_code,
  output logic [3:0] count
);
  typedef struct packed {
    logic [DEPTH-1:0][CODE_W-1:0] ent;
    logic [3:0] cnt;
    logic [CODE_W-1:0] rd;
  } store_st_t;

  store_st_t st_r;
  store_st_t st_nxt;
  logic dup;

  always_comb begin
    dup = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if ((4'(i) < st_r.cnt) && (st_r.ent[i] == code)) begin
        dup = 1'b1;
      end
    end
    st_nxt = st_r;
    if (clr) begin
      st_nxt.cnt = '0;
    end
    // full store drops new codes
    // a duplicate of an entry being cleared must still land
    if (push && (clr || (!dup && (st_r.cnt < 4'(DEPTH))))) begin
      // set wins: a code arriving with the clear becomes the only entry
      st_nxt.ent[clr ? 4'h0 : st_r.cnt] = code;
      st_nxt.cnt = clr ? 4'h1 : st_r.cnt + 4'h1;
    end
    st_nxt.rd = (rd_idx < st_r.cnt) ? st_r.ent[rd_idx] : '0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_code = st_r.rd;
  assign count = st_r.cnt;

  property p_max;
    @(posedge clk) disable iff (srst) st_r.cnt <= 4'(DEPTH);
  endproperty
  a_max: assert property (p_max) else $error("diagnostic count above limit");

  property p_hold;
    @(posedge clk) disable iff (srst)
      (!clr && st_r.cnt != 0) |=> (st_r.cnt >= $past(st_r.cnt));
  endproperty
  a_hold: assert property (p_hold) else $error("diagnostic lost without clear");

  property p_clr;
    @(posedge clk) disable iff (srst) (clr && !push) |=> (st_r.cnt == 4'h0);
  endproperty
  a_clr: assert property (p_clr) else $error("clear left diagnostics");
endmodule

// >>> dp_master_model.sv
/*
  Master model: writes the output image, one strobe per exchange.
  Assumes the bench calls send() at a falling edge of clk.
*/
`timescale 1ns/10ps
module dp_master_model (
  // clock
  input wire logic clk,
  // output image
  output logic out_valid,
  output logic [7:0] out_trig,
  output logic [7:0] out_ctrl,
  output logic [7:0] out_sel,
  output logic [7:0] out_chan,
  output logic [7:0] out_pre,
  output logic [7:0] out_len
);
  logic [7:0] trig_r = 8'h00;
  initial begin
    out_valid = 1'b0;
    {out_trig, out_ctrl, out_sel, out_chan, out_pre, out_len} = '0;
  end
  // skip breaks the trigger step on purpose
  task automatic send(input logic [7:0] c, s, ch, p, l, input logic skip);
    @(negedge clk);
    trig_r = trig_r + (skip ? 8'h02 : 8'h01);
    out_trig = trig_r;
    {out_ctrl, out_sel, out_chan, out_pre, out_len} = {c, s, ch, p, l};
    out_valid = 1'b1;
    @(negedge clk);
    out_valid = 1'b0;
    // clear bit lives in one image
    out_ctrl = 8'h00;
    // stale bytes must not look valid
    {out_sel, out_chan, out_pre, out_len} = ~{out_sel, out_chan, out_pre, out_len};
  endtask
endmodule

// >>> tb.sv
/*
  Bench for the diagnostic and input image block.
  Assumes the master model drives the image; inputs change at negedge.
*/
`timescale 1ns/10ps
module tb;
  import gw_diag_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic fmt_raw = 1'b1;
  logic cfg_valid, cfg_slot_present, cfg_slot_first, cfg_cmd_mod_present, cfg_len_mod_present;
  logic out_valid, cmd_push, cmd_sent, txq_overflow, rxq_overflow, nv_rd_fail, nv_wr_fail;
  logic rx_start, rx_byte_valid, resp_valid;
  logic [1:0] sel_mode, sel_chan, cmd_chan, resp_chan;
  logic [2:0] resp_fault;
  logic [3:0] burst_seen, resp_slave_status, diag_idx, diag_count;
  logic [4:0] diag_code;
  logic [6:0] resp_module;
  logic [7:0] cfg_burst_count, out_trig, out_ctrl, out_sel, out_chan, out_pre, out_len;
  logic [7:0] cmd_pre, cmd_len, cmd_module, rx_byte, resp_len, in_addr, in_data;
  logic [15:0] txq_count, resp_cmd_id;
  int n_fail = 0, checks = 0, n_push = 0, n_resp = 0, n_bad = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (cmd_push === 1'b1) n_push <= n_push + 1;

  dp_master_model i_master (.clk, .out_valid, .out_trig, .out_ctrl, .out_sel, .out_chan,
    .out_pre, .out_len);
  gateway_diag_and_input_map i_dut (.clk, .srst, .fmt_raw, .cfg_valid, .cfg_slot_present,
    .cfg_slot_first, .cfg_burst_count, .cfg_cmd_mod_present, .cfg_len_mod_present, .out_valid,
    .out_trig, .out_ctrl, .out_sel, .out_chan, .out_pre, .out_len, .sel_mode, .sel_chan,
    .cmd_push, .cmd_chan, .cmd_pre, .cmd_len, .cmd_module, .burst_seen, .cmd_sent,
    .txq_overflow, .rxq_overflow, .nv_rd_fail, .nv_wr_fail, .txq_count, .rx_start,
    .rx_byte_valid, .rx_byte, .resp_valid, .resp_chan, .resp_len, .resp_module, .resp_cmd_id,
    .resp_fault, .resp_slave_status, .in_addr, .in_data, .diag_idx, .diag_code, .diag_count);

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic rd_img(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    in_addr = a;
    @(negedge clk);
    d = in_data;
  endtask

  // scans every slot; order of entry is not part of the check
  task automatic chk_diag(input logic [4:0] c, input logic exp);
    logic f;
    f = 1'b0;
    for (int i = 0; i < DIAG_MAX; i++) begin
      @(negedge clk);
      diag_idx = 4'(i);
      @(negedge clk);
      f = f | (diag_code === c);
    end
    cmp("diag", exp ? 16'(c) : 16'h0, f ? 16'(c) : 16'h0);
  endtask

  task automatic clr();
    i_master.send(8'h01, 8'h00, 8'h00, 8'h05, 8'h04, 1'b0);
    repeat (3) @(negedge clk);
    cmp("diag_count", 16'h0, 16'(diag_count));
  endtask

  task automatic resp(input logic [6:0] m, input logic [2:0] f, input logic [3:0] s, int nb);
    rx_start = 1'b1;
    for (int i = 0; i < nb; i++) begin
      @(negedge clk);
      {rx_start, rx_byte_valid, rx_byte} = {2'b01, 8'hA0 + 8'(i)};
    end
    @(negedge clk);
    {rx_start, rx_byte_valid, resp_valid, resp_chan, resp_len} = {3'b001, 2'h2, 8'(nb)};
    {resp_module, resp_fault, resp_slave_status, resp_cmd_id} = {m, f, s, 16'h1230 + 16'(f)};
    rx_byte = ~rx_byte;
    @(negedge clk);
    resp_valid = 1'b0;
    n_resp++;
    if (f != 3'h0) n_bad++;
  endtask

  task automatic t_push();
    int p;
    i_master.trig_r = 8'hFE;
    i_master.send(8'h00, 8'h00, 8'h02, 8'h07, 8'h08, 1'b0);
    p = n_push;
    i_master.send(8'h00, 8'h00, 8'h02, 8'h04, 8'h08, 1'b0);
    repeat (3) @(negedge clk);
    cmp("push", 16'(p + 1), 16'(n_push));
    cmp("cmd_chan", 16'h2, 16'(cmd_chan));
    cmp("cmd_len", 16'h8, 16'(cmd_len));
    cmp("cmd_pre", 16'(PRE_SUBST), 16'(cmd_pre));
    cmp("diag_count", 16'h1, 16'(diag_count));
    chk_diag(DG_PRE_RANGE, 1'b1);
  endtask

  task automatic t_chan();
    int p;
    clr();
    p = n_push;
    i_master.send(8'h00, 8'h00, 8'h04, 8'h05, 8'h04, 1'b0);
    i_master.send(8'h00, 8'h00, 8'h03, 8'h05, 8'h04, 1'b0);
    repeat (3) @(negedge clk);
    cmp("push", 16'(p + 1), 16'(n_push));
    cmp("cmd_chan", 16'h3, 16'(cmd_chan));
    cmp("cmd_pre", 16'h5, 16'(cmd_pre));
    chk_diag(DG_CHAN_RANGE, 1'b1);
    chk_diag(DG_PRE_RANGE, 1'b0);
    i_master.send(8'h00, 8'h00, 8'h03, 8'h05, 8'h04, 1'b1);
    chk_diag(DG_LOST_OUT, 1'b1);
    chk_diag(DG_CHAN_RANGE, 1'b1);
  endtask

  task automatic t_compact();
    int p;
    clr();
    fmt_raw = 1'b0;
    sel_mode = MODE_POLLING;
    p = n_push;
    i_master.send(8'h00, 8'h03, 8'h00, 8'h05, 8'h04, 1'b0);
    chk_diag(DG_NOT_MANUAL, 1'b1);
    {sel_mode, sel_chan, burst_seen} = {MODE_MANUAL, 2'h1, 4'h2};
    i_master.send(8'h00, 8'h03, 8'h00, 8'h05, 8'h04, 1'b0);
    repeat (3) @(negedge clk);
    cmp("push", 16'(p + 1), 16'(n_push));
    cmp("cmd_chan", 16'h1, 16'(cmd_chan));
    cmp("cmd_module", 16'h3, 16'(cmd_module));
    chk_diag(DG_BURST_BUS, 1'b1);
    {cfg_len_mod_present, cfg_valid} = 2'b11;
    @(negedge clk);
    {cfg_len_mod_present, cfg_valid} = 2'b00;
    chk_diag(DG_WRONG_MOD, 1'b1);
    {fmt_raw, burst_seen} = {1'b1, 4'h0};
  endtask

  task automatic t_cfg();
    logic [4:0] c[8] = '{DG_NO_SLOT, DG_SLOT_POS, DG_TXQ_OVF, DG_BURST_MANY, DG_WRONG_MOD,
      DG_RXQ_OVF, DG_NV_RD, DG_NV_WR};
    clr();
    {cfg_slot_present, cfg_valid} = 2'b01;
    @(negedge clk);
    {cfg_slot_present, cfg_slot_first, cfg_burst_count, cfg_cmd_mod_present} = 11'h405;
    @(negedge clk);
    cfg_valid = 1'b0;
    {txq_overflow, rxq_overflow, nv_rd_fail, nv_wr_fail} = 4'hF;
    @(negedge clk);
    {txq_overflow, rxq_overflow, nv_rd_fail, nv_wr_fail} = 4'h0;
    repeat (12) @(negedge clk);
    cmp("diag_count", 16'h8, 16'(diag_count));
    for (int i = 0; i < 8; i++) chk_diag(c[i], 1'b1);
    {cfg_slot_first, cfg_burst_count, cfg_cmd_mod_present} = 10'h202;
  endtask

  task automatic t_limit();
    clr();
    resp(7'h70, 3'h1, 4'h0, 0);
    resp(7'h01, 3'h2, 4'h0, 0);
    repeat (3) @(negedge clk);
    cmp("diag_count", 16'h0, 16'(diag_count));
    for (int i = 1; i <= 8; i++) resp(i[0] ? 7'h02 : 7'h6F, 3'(i % 8), 4'(i), 0);
    txq_overflow = 1'b1;
    @(negedge clk);
    txq_overflow = 1'b0;
    repeat (6) @(negedge clk);
    cmp("diag_count", 16'(DIAG_MAX), 16'(diag_count));
    chk_diag(DG_TXQ_OVF, 1'b0);
    chk_diag(DG_RESP_BASE + 5'h6, 1'b1);
    chk_diag(DG_SLAVE_BASE + 5'h7, 1'b1);
  endtask

  task automatic t_image();
    logic [7:0] d, h;
    logic [7:0] o[4] = '{OFF_SENT, OFF_RECV, OFF_FAIL, OFF_ERRID};
    logic [15:0] e[4];
    logic [15:0] q[3] = '{16'h0, 16'h9, 16'h258};
    int f;
    repeat (3) begin
      cmd_sent = 1'b1;
      @(negedge clk);
      cmd_sent = 1'b0;
      @(negedge clk);
    end
    resp(7'h05, 3'h3, 4'h0, 6);
    e = '{16'h3, 16'(n_resp), 16'(n_bad), 16'h1233};
    for (int i = 0; i < 6; i++) begin
      rd_img(DATA_FIRST + 8'(i), d);
      cmp("rx byte", 16'(8'hA0 + 8'(i)), 16'(d));
    end
    rd_img(8'hF0, d);
    cmp("past end", 16'h0, 16'(d));
    rd_img(OFF_CHAN, d);
    cmp("chan", 16'h2, 16'(d));
    rd_img(OFF_LEN, d);
    cmp("len", 16'h6, 16'(d));
    for (int i = 0; i < 4; i++) begin
      rd_img(o[i], h);
      rd_img(o[i] + 8'h01, d);
      cmp("counter", e[i], {h, d});
    end
    for (int i = 0; i < 3; i++) begin
      txq_count = q[i];
      f = (int'(q[i]) + 1) / 2;
      f = (f < 1) ? 1 : (f > 255) ? 255 : f;
      rd_img(OFF_PEND, h);
      rd_img(OFF_PEND + 8'h01, d);
      cmp("pending", q[i], {h, d});
      rd_img(OFF_FILL, d);
      cmp("fill", 16'(f), 16'(d));
    end
  endtask

  task automatic stop_test();
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    {cfg_valid, cfg_cmd_mod_present, cfg_len_mod_present, cfg_burst_count} = '0;
    {sel_mode, sel_chan, burst_seen, cmd_sent, txq_overflow, rxq_overflow} = '0;
    {nv_rd_fail, nv_wr_fail, txq_count, rx_start, rx_byte_valid, rx_byte} = '0;
    {resp_valid, resp_chan, resp_len, resp_module, resp_cmd_id, resp_fault} = '0;
    {resp_slave_status, in_addr, diag_idx} = '0;
    {cfg_slot_present, cfg_slot_first} = 2'b11;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    t_push();
    t_chan();
    t_compact();
    t_cfg();
    t_limit();
    t_image();
    stop_test();
  end
endmodule
